// [bench/xbc_ext_bus_ctrl_tb_top.sv]
// Testbench: directed scenarios for the external bus controller
`timescale 1ns/100ps
module xbc_ext_bus_ctrl_tb_top;
	logic                         clk_sys_i = 1'b0;
	logic                         reset_i   = 1'b1;
	xbc_pkg::xbc_req_t            req       = '0;
	xbc_pkg::xbc_sys_cfg_t        sys       = 7'h04;
	xbc_pkg::xbc_bus_cfg_t        dcfg      = 13'h0001;
	xbc_pkg::xbc_addr_sel_t [3:0] wsel      = '0;
	xbc_pkg::xbc_bus_cfg_t [3:0]  wcfg      = '0;
	logic                         hold_n    = 1'b1;
	logic                         rpol      = 1'b1;
	logic [3:0]                   rdel      = 4'h0;
	logic                         v, er, ale, rd_n, wr_n, ctl_oe_n, p1_oe_n, hold_ack_pin_n, hold_ack_pin_oe_n, rdy;
	logic [15:0]                  rdat, p0o, p0i, p1a;
	logic [7:0]                   seg, seg_oe_n, sg_s, sgo_s;
	logic [4:0]                   cs_n, cs_s, csa_s;
	logic [15:0]                  d_s, p0_s;
	logic [1:0]                   p0_oe_n, oe_s;
	logic                         bus_request_pin_n, bus_request_pin_oe_n;
	logic                         hold_ack_pin_in   = 1'b1;
	logic                         e_s;
	int                           n_s, err_count = 0, checks = 0;

	xbc_ext_bus_ctrl uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req),
		.rsp_valid_o(v), .rsp_err_o(er), .rsp_rdata_o(rdat), .sys_cfg_i(sys),
		.default_bus_config_i(dcfg), .window_addr_select_i(wsel), .window_bus_config_i(wcfg),
		.port0_in_i(p0i), .port0_out_o(p0o), .port0_oe_n_o(p0_oe_n), .port1_addr_o(p1a),
		.port1_oe_n_o(p1_oe_n), .port4_seg_o(seg), .port4_seg_oe_n_o(seg_oe_n),
		.ctrl_oe_n_o(ctl_oe_n), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.chip_select_out_n_o(cs_n), .ready_i(rdy), .hold_n_i(hold_n), .hold_ack_pin_n_i(hold_ack_pin_in),
		.hold_ack_pin_n_o(hold_ack_pin_n), .hold_ack_pin_oe_n_o(hold_ack_pin_oe_n),
		.bus_request_pin_n_o(bus_request_pin_n), .bus_request_pin_oe_n_o(bus_request_pin_oe_n));
	xbc_mem_model mem (.clk_i(clk_sys_i), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.addr_i(p1a), .addr_oe_n_i(p1_oe_n), .mux_ad_i(p0o), .pol_i(rpol), .delay_i(rdel),
		.data_o(p0i), .ready_o(rdy));

	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic stop_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	// Request held until the answer pulse; counts cycles from the drive edge
	task automatic acc(input logic w, input logic [23:0] a);
		@(posedge clk_sys_i);
		#1;
		req = '{1'b1, w, a, 16'hc3a5};
		{cs_s, csa_s} = {5'h1f, 5'h1f};
		n_s = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			cs_s &= cs_n;
			n_s++;
			if (ale)
				{csa_s, sg_s, sgo_s, p0_s, oe_s} = {cs_n, seg, seg_oe_n, p0o, p0_oe_n};
		end while (!v && n_s < 200);
		{d_s, e_s} = {rdat, er};
		req.valid = 1'b0;
	endtask

	task automatic t_basic();
		acc(1'b0, 24'h001000);
		chk(24'h1, 24'(e_s));
		chk(24'h1f, 24'(cs_s));
		sys.single_chip = 1'b0;
		acc(1'b0, 24'h123456);
		chk(24'h6e0c, 24'(d_s));
		chk(24'h4, 24'(n_s));
		chk(24'h3, 24'(oe_s));
		chk(24'h1e, 24'(cs_s));
		chk(24'h1f, 24'(csa_s));
		chk(24'h12, 24'(sg_s));
		sys.chip_select_timing_bit = 1'b1;
		acc(1'b0, 24'h123456);
		chk(24'h1e, 24'(csa_s));
		for (int s = 0; s < 4; s++) begin
			sys.space = xbc_pkg::xbc_space_t'(s);
			acc(1'b0, 24'hff0000);
			chk(24'hff, 24'(sgo_s ^ xbc_pkg::XBC_SEG_MASK[s]));
		end
		sys.space = xbc_pkg::XBC_SPACE_16M;
	endtask

	task automatic t_window();
		wsel[0] = '{12'h200, 4'h1};
		wsel[1] = '{12'h200, 4'h0};
		wcfg[0] = 13'h1001;
		wcfg[1] = 13'h1801;
		acc(1'b0, 24'h200010);
		chk(24'h1b, 24'(cs_s));
		chk(24'h4a, 24'(d_s));
		acc(1'b0, 24'h201010);
		chk(24'h1d, 24'(cs_s));
		chk(24'h4a4a, 24'(d_s));
		wsel[2] = '{12'h300, 4'h0};
		wsel[3] = '{12'h300, 4'h0};
		wcfg[2] = 13'h1001;
		wcfg[3] = 13'h1001;
		acc(1'b0, 24'h300020);
		chk(24'h0f, 24'(cs_s));
		chk(24'h5a7a, 24'(d_s));
		acc(1'b0, 24'h00e100);
		chk(24'h1e, 24'(cs_s));
		sys.ext_ram_enable_bit = 1'b1;
		acc(1'b0, 24'h00e100);
		chk(24'h1, 24'(n_s));
	endtask

	task automatic t_timing();
		dcfg.wait_states = 4'h3;
		acc(1'b1, 24'h003456);
		chk(24'h7, 24'(n_s));
		dcfg.wait_states = 4'h0;
		dcfg.mode = xbc_pkg::XBC_MODE_MUX16;
		acc(1'b1, 24'h003456);
		chk(24'h3456, 24'(p0_s));
		chk(24'h0, 24'(oe_s));
		dcfg.mode = xbc_pkg::XBC_MODE_DEMUX16;
		dcfg.ready_en = 1'b1;
		rdel = 4'h3;
		for (int p = 0; p < 2; p++) begin
			{dcfg.ready_polarity_bit, rpol} = {2{p[0]}};
			// Ready idle level flips with polarity; let it clear the synchroniser first
			repeat (4) @(posedge clk_sys_i);
			acc(1'b0, 24'h003456);
			chk(24'h1, 24'(n_s > 8 && n_s < 40));
			chk(24'h6e0c, 24'(d_s));
		end
	endtask

	// Hold pins pass a synchroniser, so eight cycles are allowed
	task automatic t_hold();
		hold_n = 1'b0;
		repeat (8) @(posedge clk_sys_i);
		#1 chk(24'h1, 24'(hold_ack_pin_oe_n));
		sys.hold_enable_bit = 1'b1;
		repeat (8) @(posedge clk_sys_i);
		#1 chk(24'h0, 24'({hold_ack_pin_n, hold_ack_pin_oe_n}));
		chk(24'h1, 24'(ctl_oe_n));
		req.valid = 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1 chk(24'h0, 24'({bus_request_pin_n, bus_request_pin_oe_n}));
		req.valid = 1'b0;
		hold_n = 1'b1;
		repeat (8) @(posedge clk_sys_i);
		#1 chk(24'h2, 24'({hold_ack_pin_n, ctl_oe_n}));
	endtask

	// Slave: bus stays floated until the other master grants it
	task automatic t_slave();
		sys.port6_bit7_direction = 1'b1;
		req = '{1'b1, 1'b0, 24'h003456, 16'hc3a5};
		repeat (4) @(posedge clk_sys_i);
		#1 chk(24'h3, 24'({bus_request_pin_n, hold_ack_pin_oe_n, ctl_oe_n}));
		hold_ack_pin_in = 1'b0;
		n_s = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n_s++;
		end while (!v && n_s < 200);
		chk(24'h6e0c, 24'(rdat));
		req.valid = 1'b0;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys_i);
		#1 reset_i = 1'b0;
		t_basic();
		t_window();
		t_timing();
		t_hold();
		t_slave();
		stop_test();
	end

	initial begin
		#40000;
		err_count++;
		stop_test();
	end
endmodule // xbc_ext_bus_ctrl_tb_top

// [bench/xbc_mem_model.sv]
// Partner model: external memory answering on the first port
`timescale 1ns/100ps
module xbc_mem_model (
	input  wire logic        clk_i,
	input  wire logic        ale_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        addr_oe_n_i,
	input  wire logic [15:0] mux_ad_i,
	input  wire logic        pol_i,
	input  wire logic [3:0]  delay_i,
	output logic [15:0]      data_o,
	output logic             ready_o
);
	logic [15:0] addr = 16'h0000;
	logic [3:0]  cnt  = 4'h0;
	always @(posedge clk_i) begin
		if (ale_i)
			addr <= addr_oe_n_i ? mux_ad_i : addr_i;
		cnt <= (rd_n_i & wr_n_i) ? 4'h0 : cnt + 4'h1;
	end
	// Released bus shows the inverse, so a late sample cannot match
	assign data_o = rd_n_i ? ~(addr ^ 16'h5a5a) : addr ^ 16'h5a5a;
	// Slow device: ready active only after delay_i cycles of strobe
	assign ready_o = (!(rd_n_i & wr_n_i) && cnt >= delay_i) ? pol_i : ~pol_i;
endmodule // xbc_mem_model

// [core/xbc_ext_bus_ctrl.sv]
// Module: external bus controller, CPU request side to port pins
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Summary of operation
// - Single-chip mode leaves the bus undriven; four external modes exist.
// - Each mode: 16 or 8 bit data, muxed or not, 16-24 bit address.
// - Demuxed: address on second port, data on first, low byte if 8-bit.
// - Muxed: first port carries address, then data on the same lines.
// - Cycle time, tri-state time, ALE length and read/write delay programmable.
// - Four address windows, each a select and configuration pair.
// - Window four beats three, window two beats one on overlap.
// - Addresses outside all windows use the default configuration.
// - Five chip selects: one per window plus default region.
// - Ready-enabled window cycles are extended until device drives ready active.
// - Ready active level chosen per window by its polarity bit.
// - Arbitration off until hold enable set; then pins belong to controller.
// - Master after reset; direction bit one makes hold-acknowledge an input.
// - Segment lines: eight for 16M, four 1M, two 256K, none 64K.
// - By default chip selects change half a cycle after ALE rises.
// - With chip select timing bit set they change with ALE rising.
// - Disabled extension RAM range goes external using the matching window.
// ----------------------------------------------------------------------
module xbc_ext_bus_ctrl (
	input  wire logic                                  clk_sys_i,
	input  wire logic                                  reset_i,
	input  wire xbc_pkg::xbc_req_t                     req_i,
	output logic                                       rsp_valid_o,
	output logic                                       rsp_err_o,
	output logic [15:0]                                rsp_rdata_o,
	input  wire xbc_pkg::xbc_sys_cfg_t                 sys_cfg_i,
	input  wire xbc_pkg::xbc_bus_cfg_t                 default_bus_config_i,
	input  wire xbc_pkg::xbc_addr_sel_t [3:0]          window_addr_select_i,
	input  wire xbc_pkg::xbc_bus_cfg_t [3:0]           window_bus_config_i,
	input  wire logic [15:0]                           port0_in_i,
	output logic [15:0]                                port0_out_o,
	output logic [1:0]                                 port0_oe_n_o,
	output logic [15:0]                                port1_addr_o,
	output logic                                       port1_oe_n_o,
	output logic [7:0]                                 port4_seg_o,
	output logic [7:0]                                 port4_seg_oe_n_o,
	output logic                                       ctrl_oe_n_o,
	output logic                                       ale_o,
	output logic                                       rd_n_o,
	output logic                                       wr_n_o,
	output logic [4:0]                                 chip_select_out_n_o,
	input  wire logic                                  ready_i,
	input  wire logic                                  hold_n_i,
	input  wire logic                                  hold_ack_pin_n_i,
	output logic                                       hold_ack_pin_n_o,
	output logic                                       hold_ack_pin_oe_n_o,
	output logic                                       bus_request_pin_n_o,
	output logic                                       bus_request_pin_oe_n_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	xbc_pkg::xbc_regs_t                regs;
	xbc_pkg::xbc_regs_t                next_regs;
	xbc_pkg::xbc_bus_cfg_t [4:0]       all_cfg;
	logic [3:0]                        win_hit;
	logic [2:0]                        win_sel;
	logic                              xram_hit;
	logic                              slave_mode;
	logic                              master_arb;
	logic                              hold_req;
	logic                              accept_ext;
	logic                              launch;
	xbc_pkg::xbc_bus_cfg_t             l_cfg;
	xbc_pkg::xbc_req_t                 l_req;
	logic [2:0]                        l_idx;
	logic [4:0]                        cs_dec;
	logic [4:0]                        l_cs_dec;
	logic [7:0]                        seg_mask;

	function automatic logic is_mux(input xbc_pkg::xbc_bus_mode_t m);
		return (m == xbc_pkg::XBC_MODE_MUX16) || (m == xbc_pkg::XBC_MODE_MUX8);
	endfunction

	function automatic logic is_narrow(input xbc_pkg::xbc_bus_mode_t m);
		return (m == xbc_pkg::XBC_MODE_MUX8) || (m == xbc_pkg::XBC_MODE_DEMUX8);
	endfunction

	function automatic logic [4:0] cs_of(input xbc_pkg::xbc_bus_cfg_t c, input logic [2:0] i);
		logic [4:0] v;
		v = xbc_pkg::XBC_CS_IDLE;
		if (c.cs_en) begin
			v[i] = 1'b0;
		end
		return v;
	endfunction

	// ------------------------------------------------------------------
	// Window decode
	// ------------------------------------------------------------------
	assign all_cfg[0] = default_bus_config_i;

	// Window size is 4K bytes shifted by the size code; a code of 12 or more covers all
	generate
		for (genvar g = 0; g < xbc_pkg::XBC_WIN_NUM; g++) begin : g_win
			logic [11:0] mask;
			assign mask = ~((xbc_pkg::XBC_PAGE_ONE << window_addr_select_i[g].size)
				- xbc_pkg::XBC_PAGE_ONE);
			assign all_cfg[g + 1] = window_bus_config_i[g];
			assign win_hit[g] = window_bus_config_i[g].active
				&& ((req_i.addr[23:12] & mask) == (window_addr_select_i[g].start & mask));
		end
	endgenerate

	// Later tests win, so the higher window of each pair takes over
	always_comb begin
		win_sel = 3'h0;
		if (win_hit[0]) begin
			win_sel = 3'h1;
		end
		if (win_hit[1]) begin
			win_sel = 3'h2;
		end
		if (win_hit[2]) begin
			win_sel = 3'h3;
		end
		if (win_hit[3]) begin
			win_sel = 3'h4;
		end
	end

	// Only an enabled extension RAM keeps its range off the pins
	assign xram_hit = sys_cfg_i.ext_ram_enable_bit && (req_i.addr >= xbc_pkg::XBC_XRAM_FIRST)
		&& (req_i.addr <= xbc_pkg::XBC_XRAM_LAST);

	assign slave_mode = regs.hold_armed && sys_cfg_i.port6_bit7_direction;
	assign master_arb = regs.hold_armed && !sys_cfg_i.port6_bit7_direction;
	assign hold_req   = master_arb && !regs.pin_flt[xbc_pkg::XBC_PIN_HOLD_N];
	assign accept_ext = (regs.st == xbc_pkg::XBC_ST_IDLE) && req_i.valid && !regs.rsp_valid
		&& !hold_req && !sys_cfg_i.single_chip && !xram_hit;
	assign cs_dec     = cs_of(regs.cfg, regs.win_idx);
	assign seg_mask   = xbc_pkg::XBC_SEG_MASK[sys_cfg_i.space];

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_regs = regs;
		launch = 1'b0;
		l_cfg = regs.cfg;
		l_req = regs.cur;
		l_idx = regs.win_idx;
		// Ready, hold and hold-acknowledge come from other clock domains
		next_regs.sync1 = {ready_i, hold_n_i, hold_ack_pin_n_i};
		next_regs.sync2 = regs.sync1;
		next_regs.sync3 = regs.sync2;
		for (int b = 0; b < 3; b++) begin
			if (regs.sync2[b] == regs.sync3[b]) begin
				next_regs.pin_flt[b] = regs.sync3[b];
			end
		end
		next_regs.rsp_valid = 1'b0;
		next_regs.rsp_err = 1'b0;
		// Once armed, arbitration stays on until reset
		if (sys_cfg_i.hold_enable_bit) begin
			next_regs.hold_armed = 1'b1;
		end
		next_regs.hold_ack_pin_oe_n = !master_arb;
		next_regs.bus_request_pin_oe_n = !regs.hold_armed;
		case (regs.st)
			xbc_pkg::XBC_ST_IDLE: begin
				next_regs.ale = 1'b0;
				next_regs.rd_n = 1'b1;
				next_regs.wr_n = 1'b1;
				next_regs.cs_n = xbc_pkg::XBC_CS_IDLE;
				next_regs.hold_ack_pin_n = 1'b1;
				next_regs.bus_request_pin_n = 1'b1;
				next_regs.port0_oe_n = 2'h3;
				next_regs.ctrl_oe_n = sys_cfg_i.single_chip || slave_mode;
				next_regs.port1_oe_n = sys_cfg_i.single_chip || slave_mode;
				next_regs.seg_oe_n = (sys_cfg_i.single_chip || slave_mode) ? 8'hff : ~seg_mask;
				if (hold_req) begin
					// Float first; acknowledge follows one cycle later
					next_regs.st = xbc_pkg::XBC_ST_HELD;
					next_regs.ctrl_oe_n = 1'b1;
					next_regs.port1_oe_n = 1'b1;
					next_regs.seg_oe_n = 8'hff;
				end else if (req_i.valid && !regs.rsp_valid) begin
					if (sys_cfg_i.single_chip || xram_hit) begin
						next_regs.rsp_valid = 1'b1;
						next_regs.rsp_err = sys_cfg_i.single_chip;
						next_regs.rsp_rdata = 16'h0000;
					end else begin
						next_regs.cur = req_i;
						next_regs.cfg = all_cfg[win_sel];
						next_regs.win_idx = win_sel;
						l_req = req_i;
						l_cfg = all_cfg[win_sel];
						l_idx = win_sel;
						if (slave_mode) begin
							next_regs.st = xbc_pkg::XBC_ST_GRANT;
							next_regs.bus_request_pin_n = 1'b0;
						end else begin
							launch = 1'b1;
						end
					end
				end
			end
			xbc_pkg::XBC_ST_GRANT: begin
				next_regs.bus_request_pin_n = 1'b0;
				if (!regs.pin_flt[xbc_pkg::XBC_PIN_HOLD_ACK_PIN_N]) begin
					launch = 1'b1;
				end
			end
			xbc_pkg::XBC_ST_ADDR: begin
				next_regs.cs_n = cs_dec;
				if (regs.cnt != xbc_pkg::XBC_CNT_ZERO) begin
					next_regs.cnt = regs.cnt - xbc_pkg::XBC_CNT_ONE;
				end else begin
					next_regs.ale = 1'b0;
					next_regs.cnt = regs.cfg.wait_states;
					// Muxed lines turn round to data here
					next_regs.port0_out = regs.cur.wdata;
					next_regs.port0_oe_n = regs.cur.write
						? {is_narrow(regs.cfg.mode), 1'b0} : 2'h3;
					if (regs.cfg.rw_delay) begin
						next_regs.st = xbc_pkg::XBC_ST_DELAY;
					end else begin
						next_regs.st = xbc_pkg::XBC_ST_STROBE;
						next_regs.rd_n = regs.cur.write;
						next_regs.wr_n = !regs.cur.write;
					end
				end
			end
			xbc_pkg::XBC_ST_DELAY: begin
				next_regs.st = xbc_pkg::XBC_ST_STROBE;
				next_regs.rd_n = regs.cur.write;
				next_regs.wr_n = !regs.cur.write;
			end
			xbc_pkg::XBC_ST_STROBE: begin
				if (regs.cnt != xbc_pkg::XBC_CNT_ZERO) begin
					next_regs.cnt = regs.cnt - xbc_pkg::XBC_CNT_ONE;
				end else if (!regs.cfg.ready_en || (regs.pin_flt[xbc_pkg::XBC_PIN_READY]
						== regs.cfg.ready_polarity_bit)) begin
					// Data is stable while the strobe is held, so it is taken directly
					next_regs.rsp_rdata = is_narrow(regs.cfg.mode)
						? {8'h00, port0_in_i[7:0]} : port0_in_i;
					next_regs.rd_n = 1'b1;
					next_regs.wr_n = 1'b1;
					next_regs.st = xbc_pkg::XBC_ST_RECOVER;
					next_regs.cnt = regs.cfg.tristate_wait
						? xbc_pkg::XBC_CNT_ONE : xbc_pkg::XBC_CNT_ZERO;
				end
			end
			xbc_pkg::XBC_ST_RECOVER: begin
				next_regs.port0_oe_n = 2'h3;
				if (regs.cnt != xbc_pkg::XBC_CNT_ZERO) begin
					next_regs.cnt = regs.cnt - xbc_pkg::XBC_CNT_ONE;
				end else begin
					next_regs.st = xbc_pkg::XBC_ST_IDLE;
					next_regs.cs_n = xbc_pkg::XBC_CS_IDLE;
					next_regs.rsp_valid = 1'b1;
				end
			end
			xbc_pkg::XBC_ST_HELD: begin
				next_regs.hold_ack_pin_n = 1'b0;
				next_regs.bus_request_pin_n = !(req_i.valid && !regs.rsp_valid);
				if (regs.pin_flt[xbc_pkg::XBC_PIN_HOLD_N]) begin
					next_regs.hold_ack_pin_n = 1'b1;
					next_regs.bus_request_pin_n = 1'b1;
					next_regs.st = xbc_pkg::XBC_ST_IDLE;
				end
			end
			default: begin
				next_regs.st = xbc_pkg::XBC_ST_IDLE;
			end
		endcase
		l_cs_dec = cs_of(l_cfg, l_idx);
		if (launch) begin
			next_regs.st = xbc_pkg::XBC_ST_ADDR;
			next_regs.cnt = l_cfg.ale_long ? xbc_pkg::XBC_CNT_ONE : xbc_pkg::XBC_CNT_ZERO;
			next_regs.ale = 1'b1;
			next_regs.ctrl_oe_n = 1'b0;
			next_regs.port1_addr = l_req.addr[15:0];
			next_regs.port1_oe_n = is_mux(l_cfg.mode);
			next_regs.seg = l_req.addr[23:16] & seg_mask;
			next_regs.seg_oe_n = ~seg_mask;
			next_regs.port0_out = l_req.addr[15:0];
			next_regs.port0_oe_n = is_mux(l_cfg.mode) ? 2'h0 : 2'h3;
			// Without the timing bit the selects follow one tick, half a CPU clock, later
			next_regs.cs_n = sys_cfg_i.chip_select_timing_bit
				? l_cs_dec : xbc_pkg::XBC_CS_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			regs <= xbc_pkg::XBC_REGS_RESET;
		end else begin
			regs <= next_regs;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rsp_valid_o            = regs.rsp_valid;
	assign rsp_err_o              = regs.rsp_err;
	assign rsp_rdata_o            = regs.rsp_rdata;
	assign port0_out_o            = regs.port0_out;
	assign port0_oe_n_o           = regs.port0_oe_n;
	assign port1_addr_o           = regs.port1_addr;
	assign port1_oe_n_o           = regs.port1_oe_n;
	assign port4_seg_o            = regs.seg;
	assign port4_seg_oe_n_o       = regs.seg_oe_n;
	assign ctrl_oe_n_o            = regs.ctrl_oe_n;
	assign ale_o                  = regs.ale;
	assign rd_n_o                 = regs.rd_n;
	assign wr_n_o                 = regs.wr_n;
	assign chip_select_out_n_o    = regs.cs_n;
	assign hold_ack_pin_n_o       = regs.hold_ack_pin_n;
	assign hold_ack_pin_oe_n_o    = regs.hold_ack_pin_oe_n;
	assign bus_request_pin_n_o    = regs.bus_request_pin_n;
	assign bus_request_pin_oe_n_o = regs.bus_request_pin_oe_n;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	a_single_chip_local: assert property (
		(regs.st == xbc_pkg::XBC_ST_IDLE && req_i.valid && !regs.rsp_valid && !hold_req
			&& sys_cfg_i.single_chip)
		|=> (rsp_valid_o && rsp_err_o && !ale_o && ctrl_oe_n_o))
		else $error("single-chip access reached the pins");

	a_narrow_high_lane: assert property (
		(regs.st == xbc_pkg::XBC_ST_STROBE && is_narrow(regs.cfg.mode)) |-> port0_oe_n_o[1])
		else $error("high data lane driven on 8-bit bus");

	a_mux_addr_phase: assert property (
		(ale_o && is_mux(regs.cfg.mode))
		|-> (port0_out_o == regs.cur.addr[15:0] && port0_oe_n_o == 2'h0 && port1_oe_n_o))
		else $error("muxed address phase wrong on first port");

	a_ale_length: assert property (
		$rose(ale_o) |-> if (regs.cfg.ale_long) (ale_o[*2] ##1 !ale_o) else (##1 !ale_o))
		else $error("address latch strobe length wrong");

	a_window_priority: assert property (
		(accept_ext && win_hit[3]) |=> (regs.win_idx == 3'h4))
		else $error("window four did not take precedence");

	a_pair_priority: assert property (
		(accept_ext && win_hit[1] && !win_hit[2] && !win_hit[3]) |=> (regs.win_idx == 3'h2))
		else $error("window two did not take precedence");

	a_default_config: assert property (
		(accept_ext && win_hit == 4'h0)
		|=> (regs.win_idx == 3'h0 && regs.cfg == $past(default_bus_config_i)))
		else $error("unmatched access not on default configuration");

	a_ready_extends: assert property (
		(regs.st == xbc_pkg::XBC_ST_STROBE && regs.cnt == xbc_pkg::XBC_CNT_ZERO
			&& regs.cfg.ready_en
			&& regs.pin_flt[xbc_pkg::XBC_PIN_READY] != regs.cfg.ready_polarity_bit)
		|=> (regs.st == xbc_pkg::XBC_ST_STROBE && !(rd_n_o && wr_n_o)))
		else $error("cycle ended without active ready");

	a_hold_disarmed: assert property (
		!regs.hold_armed |=> (hold_ack_pin_oe_n_o && bus_request_pin_oe_n_o))
		else $error("arbitration pins taken before hold enable");

	a_segment_lines: assert property (
		(ale_o && sys_cfg_i.space == xbc_pkg::XBC_SPACE_1M) |-> (port4_seg_oe_n_o == 8'hf0))
		else $error("wrong number of segment lines");

	a_cs_late: assert property (
		($rose(ale_o) && !sys_cfg_i.chip_select_timing_bit)
		|-> (chip_select_out_n_o == xbc_pkg::XBC_CS_IDLE) ##1 (chip_select_out_n_o == cs_dec))
		else $error("chip select not one tick after address strobe");

	a_cs_with_ale: assert property (
		($rose(ale_o) && sys_cfg_i.chip_select_timing_bit) |-> (chip_select_out_n_o == cs_dec))
		else $error("chip select not with address strobe");

	a_float_before_ack: assert property (
		$fell(hold_ack_pin_n_o) |-> ($past(ctrl_oe_n_o) && port0_oe_n_o == 2'h3 && ctrl_oe_n_o))
		else $error("hold acknowledged while bus driven");

	a_xram_local: assert property (
		(regs.st == xbc_pkg::XBC_ST_IDLE && req_i.valid && !regs.rsp_valid && !hold_req
			&& xram_hit && !sys_cfg_i.single_chip) |=> (rsp_valid_o && !rsp_err_o && !ale_o))
		else $error("enabled extension RAM access went external");

endmodule // xbc_ext_bus_ctrl

// [core/xbc_pkg.sv]
// Package: constants, carriers and state layout of the external bus controller
package xbc_pkg;

	// ------------------------------------------------------------------
	// Sizes and fixed values
	// ------------------------------------------------------------------
	localparam int          XBC_WIN_NUM    = 4;
	localparam int          XBC_CS_NUM     = 5;
	localparam logic [23:0] XBC_XRAM_FIRST = 24'h00e000;
	localparam logic [23:0] XBC_XRAM_LAST  = 24'h00e7ff;
	localparam logic [4:0]  XBC_CS_IDLE    = 5'h1f;
	localparam logic [3:0]  XBC_CNT_ZERO   = 4'h0;
	localparam logic [3:0]  XBC_CNT_ONE    = 4'h1;
	localparam logic [11:0] XBC_PAGE_ONE   = 12'h001;

	// Synchronised pins: bit positions and value after reset
	localparam int          XBC_PIN_READY  = 2;
	localparam int          XBC_PIN_HOLD_N = 1;
	localparam int          XBC_PIN_HOLD_ACK_PIN_N = 0;
	localparam logic [2:0]  XBC_PIN_RESET  = 3'h3;

	// Segment lines driven per address space, index is xbc_space_t
	localparam logic [3:0][7:0] XBC_SEG_MASK = {8'h00, 8'h03, 8'h0f, 8'hff};

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		XBC_MODE_DEMUX16 = 2'h0,
		XBC_MODE_MUX16   = 2'h1,
		XBC_MODE_MUX8    = 2'h2,
		XBC_MODE_DEMUX8  = 2'h3
	} xbc_bus_mode_t;

	typedef enum logic [1:0] {
		XBC_SPACE_16M  = 2'h0,
		XBC_SPACE_1M   = 2'h1,
		XBC_SPACE_256K = 2'h2,
		XBC_SPACE_64K  = 2'h3
	} xbc_space_t;

	typedef enum logic [2:0] {
		XBC_ST_IDLE    = 3'h0,
		XBC_ST_ADDR    = 3'h1,
		XBC_ST_DELAY   = 3'h2,
		XBC_ST_STROBE  = 3'h3,
		XBC_ST_RECOVER = 3'h4,
		XBC_ST_HELD    = 3'h5,
		XBC_ST_GRANT   = 3'h6
	} xbc_state_t;

	typedef struct packed {
		logic          active;
		xbc_bus_mode_t mode;
		logic [3:0]    wait_states;
		logic          tristate_wait;
		logic          ale_long;
		logic          rw_delay;
		logic          ready_en;
		logic          ready_polarity_bit;
		logic          cs_en;
	} xbc_bus_cfg_t;

	typedef struct packed {
		logic [11:0] start;
		logic [3:0]  size;
	} xbc_addr_sel_t;

	typedef struct packed {
		logic       hold_enable_bit;
		logic       chip_select_timing_bit;
		logic       port6_bit7_direction;
		logic       ext_ram_enable_bit;
		logic       single_chip;
		xbc_space_t space;
	} xbc_sys_cfg_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [23:0] addr;
		logic [15:0] wdata;
	} xbc_req_t;

	typedef struct packed {
		xbc_state_t   st;
		logic [3:0]   cnt;
		logic         hold_armed;
		logic [2:0]   sync1;
		logic [2:0]   sync2;
		logic [2:0]   sync3;
		logic [2:0]   pin_flt;
		xbc_req_t     cur;
		xbc_bus_cfg_t cfg;
		logic [2:0]   win_idx;
		logic [15:0]  port0_out;
		logic [1:0]   port0_oe_n;
		logic [15:0]  port1_addr;
		logic         port1_oe_n;
		logic [7:0]   seg;
		logic [7:0]   seg_oe_n;
		logic         ctrl_oe_n;
		logic         ale;
		logic         rd_n;
		logic         wr_n;
		logic [4:0]   cs_n;
		logic         bus_request_pin_n;
		logic         bus_request_pin_oe_n;
		logic         hold_ack_pin_n;
		logic         hold_ack_pin_oe_n;
		logic         rsp_valid;
		logic         rsp_err;
		logic [15:0]  rsp_rdata;
	} xbc_regs_t;

	localparam xbc_regs_t XBC_REGS_RESET = '{
		st: XBC_ST_IDLE, cnt: 4'h0, hold_armed: 1'b0,
		sync1: XBC_PIN_RESET, sync2: XBC_PIN_RESET, sync3: XBC_PIN_RESET,
		pin_flt: XBC_PIN_RESET, cur: '0, cfg: '0, win_idx: 3'h0,
		port0_out: 16'h0000, port0_oe_n: 2'h3, port1_addr: 16'h0000, port1_oe_n: 1'b1,
		seg: 8'h00, seg_oe_n: 8'hff, ctrl_oe_n: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
		cs_n: XBC_CS_IDLE, bus_request_pin_n: 1'b1, bus_request_pin_oe_n: 1'b1, hold_ack_pin_n: 1'b1, hold_ack_pin_oe_n: 1'b1,
		rsp_valid: 1'b0, rsp_err: 1'b0, rsp_rdata: 16'h0000
	};

endpackage
